// ---- hdl/addr_decoder_cfg.svh ----
/*
 * constants of the system address decoder: region geometry, fixed internal
 * bases, external default bases and reset values.
 * assumes a 32-bit byte address bus.
 */
`ifndef ADDR_DECODER_CFG_SVH
`define ADDR_DECODER_CFG_SVH

`define REGION_SHIFT       26
`define REGION_SIZE_MB     64
`define INT_REGION_COUNT   7
`define INT_SEL_MSB        31
`define INT_SEL_LSB        24
`define PERIPH_BASE_TOP    8'hff
`define DSPB_PRAM_TOP      8'hfe
`define DSPA_PRAM_TOP      8'hfd
`define RSVD_TOP           8'hfc
`define DSPB_MBOX_TOP      8'hfb
`define DSPA_MBOX_TOP      8'hfa
`define BOOT_ROM_TOP       8'hf9
`define INT_FLOOR_TOP      8'hf9
`define PERIPH_WIN_SHIFT   14
`define PERIPH_WIN_BITS    6
`define PRAM_WORDS         24576
`define MBOX_WORDS         2048
`define ROM_WORDS          1024
`define EXT_COUNT          6
`define EXT_BASE_W         6
`define SMC0_BASE_RST      32'h00000000
`define SMC1_BASE_RST      32'h01000000
`define SMC2_BASE_RST      32'h20000000
`define SMC3_BASE_RST      32'h30000000
`define DMC0_BASE_RST      32'h04000000
`define DMC1_BASE_RST      32'h05000000
`define EXT_EN_RST         6'h3f
`define RDATA_ZERO         32'h00000000

`endif

// ---- hdl/addr_decoder_pkg.sv ----
/*
 * types shared by the system address decoder files.
 * assumes addr_decoder_cfg.svh for all numeric values.
 */
`include "addr_decoder_cfg.svh"

package addr_decoder_pkg;

    // binary-encoded target enumeration, one value per access
    typedef enum logic [3:0] {
        TGT_NONE      = 4'h0,
        TGT_PERIPH    = 4'h1,
        TGT_DSPB_PRAM = 4'h2,
        TGT_DSPA_PRAM = 4'h3,
        TGT_DSPB_MBOX = 4'h4,
        TGT_DSPA_MBOX = 4'h5,
        TGT_BOOT_ROM  = 4'h6,
        TGT_SMC       = 4'h7,
        TGT_DMC       = 4'h8
    } target_t;

    // bases of the six external regions in 64 MB units
    typedef struct packed {
        logic [5:0] smc0;
        logic [5:0] smc1;
        logic [5:0] smc2;
        logic [5:0] smc3;
        logic [5:0] dmc0;
        logic [5:0] dmc1;
    } ext_bases_t;

    // routing decision for one access
    typedef struct packed {
        target_t    target;
        logic [1:0] ext_select;   // chip select index inside the controller
        logic [5:0] periph_slot;  // 16 KB window number
        logic       bridge;       // access goes over the peripheral bus
        logic       null_access;  // read zero, drop write
    } route_t;

endpackage : addr_decoder_pkg

// ---- hdl/region_matcher.sv ----
/*
 * combinational region decode: maps a byte address to one target.
 * assumes bases and enables are stable registers in the caller's domain.
 */
`timescale 1ns/1ps
`include "addr_decoder_cfg.svh"

module region_matcher
    import addr_decoder_pkg::*;
(
    input  wire logic [31:0] addr_i,      // bus byte address
    input  wire ext_bases_t  bases_i,     // external region bases
    input  wire logic [5:0]  ext_en_i,    // external region enables
    input  wire logic        rom_remap_i, // low: boot rom at zero
    output route_t           route_o      // decision
);

    // compare top six address bits with one base
    function automatic logic hit(input logic [31:0] a, input logic [5:0] b, input logic en);
        hit = en && (a[31:`REGION_SHIFT] == b);
    endfunction : hit

    // fixed internal map first, then remap, then external regions
    always_comb begin
        route_o             = '0;
        route_o.target      = TGT_NONE;
        route_o.null_access = 1'b1;
        if (addr_i[`INT_SEL_MSB:`INT_SEL_LSB] >= `INT_FLOOR_TOP) begin
            case (addr_i[`INT_SEL_MSB:`INT_SEL_LSB])
                `PERIPH_BASE_TOP: begin
                    route_o.target      = TGT_PERIPH;
                    route_o.bridge      = 1'b1;
                    route_o.periph_slot = addr_i[`PERIPH_WIN_SHIFT +: `PERIPH_WIN_BITS];
                end
                `DSPB_PRAM_TOP: route_o.target = TGT_DSPB_PRAM;
                `DSPA_PRAM_TOP: route_o.target = TGT_DSPA_PRAM;
                `DSPB_MBOX_TOP: route_o.target = TGT_DSPB_MBOX;
                `DSPA_MBOX_TOP: route_o.target = TGT_DSPA_MBOX;
                `BOOT_ROM_TOP:  route_o.target = TGT_BOOT_ROM;
                default:        route_o.target = TGT_NONE;
            endcase
        end else if (!rom_remap_i && addr_i[31:`REGION_SHIFT] == 6'h00) begin
            route_o.target = TGT_BOOT_ROM;
        end else if (hit(addr_i, bases_i.smc0, ext_en_i[0])) begin
            route_o.target = TGT_SMC;
        end else if (hit(addr_i, bases_i.smc1, ext_en_i[1])) begin
            route_o.target     = TGT_SMC;
            route_o.ext_select = 2'h1;
        end else if (hit(addr_i, bases_i.smc2, ext_en_i[2])) begin
            route_o.target     = TGT_SMC;
            route_o.ext_select = 2'h2;
        end else if (hit(addr_i, bases_i.smc3, ext_en_i[3])) begin
            route_o.target     = TGT_SMC;
            route_o.ext_select = 2'h3;
        end else if (hit(addr_i, bases_i.dmc0, ext_en_i[4])) begin
            route_o.target = TGT_DMC;
        end else if (hit(addr_i, bases_i.dmc1, ext_en_i[5])) begin
            route_o.target     = TGT_DMC;
            route_o.ext_select = 2'h1;
        end
        // one target per access; none means a null access
        if (route_o.target != TGT_NONE) begin
            route_o.null_access = 1'b0;
        end
    end

endmodule : region_matcher

// ---- hdl/system_address_decoder.sv ----
/*
 * system address decoder: region map of the system bus with boot remap.
 * assumes one 20 MHz clock, synchronous reset, the memory controllers
 * supplying region bases, and targets answering in the cycle after select.
 */
// Summary of operation
// - address space split into 64 MB regions
// - top seven 16 MB regions hold internal targets
// - six external regions, static or dynamic
// - external regions take default bases at reset
// - external bases reprogrammable, internal fixed
// - address zero goes to rom or external
// - remapped zero served by region zero
// - peripherals at top, 16 KB windows
// - second dsp program ram region
// - first dsp program ram; one reserved
// - two dsp mailbox regions
// - system bus reaches dsps and external bus
// - peripherals reached through bridge
// - little-endian byte ordering throughout
// - remap flag loaded from boot pin
// - software setting remap flag removes rom from zero
`timescale 1ns/1ps
`include "addr_decoder_cfg.svh"

module system_address_decoder
    import addr_decoder_pkg::*;
(
    input  wire logic        mclk_i,           // system clock 20 MHz
    input  wire logic        sys_rst_i,        // synchronous reset, high
    input  wire logic        boot_select_pin_i,// boot pin, async
    input  wire logic        remap_set_i,      // software sets remap flag
    input  wire logic        base_wr_i,        // controller base update strobe
    input  wire logic [2:0]  base_idx_i,       // 0..3 static, 4..5 dram
    input  wire logic [5:0]  base_val_i,       // new base, 64 MB units
    input  wire logic        base_en_i,        // new enable for that region
    input  wire logic        req_i,            // bus access request
    input  wire logic        wr_i,             // write access
    input  wire logic [31:0] addr_i,           // byte address
    input  wire logic [3:0]  be_i,             // byte lanes, lane0 = low byte
    input  wire logic [31:0] wdata_i,          // write data
    input  wire logic [31:0] tgt_rdata_i,      // data from selected target
    output target_t          target_o,         // registered target
    output logic [1:0]       ext_select_o,     // chip select index
    output logic [5:0]       periph_slot_o,    // peripheral window
    output logic             bridge_o,         // via peripheral bridge
    output logic             tgt_req_o,        // access to a real target
    output logic             tgt_wr_o,         // write to real target
    output logic [31:0]      tgt_addr_o,       // address to target
    output logic [3:0]       tgt_be_o,         // byte lanes to target
    output logic [31:0]      tgt_wdata_o,      // write data to target
    output logic             ack_o,            // access done pulse
    output logic [31:0]      rdata_o,          // read data to bus
    output logic             rom_remap_o       // remap flag state
);

    ext_bases_t   bases_q;
    logic [5:0]   ext_en_q;
    logic         boot_s1_q;
    logic         boot_s2_q;
    logic         rst_seen_q;
    logic         rom_remap_q;
    logic         pend_q;
    logic         pend_null_q;
    route_t       route;

    // top six address bits give the 64 MB region number
    function automatic logic [5:0] region_of(input logic [31:0] a);
        region_of = a[31:`REGION_SHIFT];
    endfunction : region_of

    // boot pin comes from outside; two flops before use
    always_ff @(posedge mclk_i) begin
        boot_s1_q <= boot_select_pin_i;
        boot_s2_q <= boot_s1_q;
    end

    // external bases: defaults at reset, controllers may move them
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            bases_q.smc0 <= region_of(`SMC0_BASE_RST);
            bases_q.smc1 <= region_of(`SMC1_BASE_RST);
            bases_q.smc2 <= region_of(`SMC2_BASE_RST);
            bases_q.smc3 <= region_of(`SMC3_BASE_RST);
            bases_q.dmc0 <= region_of(`DMC0_BASE_RST);
            bases_q.dmc1 <= region_of(`DMC1_BASE_RST);
            ext_en_q     <= `EXT_EN_RST;
        end else if (base_wr_i) begin
            // no overlap check; overlapping bases are software's fault
            case (base_idx_i)
                3'h0:    bases_q.smc0 <= base_val_i;
                3'h1:    bases_q.smc1 <= base_val_i;
                3'h2:    bases_q.smc2 <= base_val_i;
                3'h3:    bases_q.smc3 <= base_val_i;
                3'h4:    bases_q.dmc0 <= base_val_i;
                3'h5:    bases_q.dmc1 <= base_val_i;
                default: bases_q.smc0 <= bases_q.smc0;
            endcase
            if (base_idx_i < 3'h6) begin
                ext_en_q[base_idx_i] <= base_en_i;
            end
        end
    end

    // remap flag: caught from the pin on the first edge after release
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rst_seen_q  <= 1'b1;
            rom_remap_q <= 1'b0;
        end else if (rst_seen_q) begin
            rst_seen_q  <= 1'b0;
            // a software set in the load cycle is not lost
            rom_remap_q <= boot_s2_q || remap_set_i;
        end else if (remap_set_i) begin
            rom_remap_q <= 1'b1;
        end
    end

    region_matcher u_match (
        .addr_i      (addr_i),
        .bases_i     (bases_q),
        .ext_en_i    (ext_en_q),
        .rom_remap_i (rom_remap_q),
        .route_o     (route)
    );

    // request stage: target chosen, address and lanes passed unchanged
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            target_o      <= TGT_NONE;
            ext_select_o  <= 2'h0;
            periph_slot_o <= 6'h00;
            bridge_o      <= 1'b0;
            tgt_req_o     <= 1'b0;
            tgt_wr_o      <= 1'b0;
            tgt_addr_o    <= `RDATA_ZERO;
            tgt_be_o      <= 4'h0;
            tgt_wdata_o   <= `RDATA_ZERO;
            pend_q        <= 1'b0;
            pend_null_q   <= 1'b0;
        end else begin
            pend_q      <= req_i;
            pend_null_q <= req_i && route.null_access;
            tgt_req_o   <= req_i && !route.null_access;
            tgt_wr_o    <= req_i && wr_i && !route.null_access;
            if (req_i) begin
                target_o      <= route.target;
                ext_select_o  <= route.ext_select;
                periph_slot_o <= route.periph_slot;
                bridge_o      <= route.bridge;
                tgt_addr_o    <= addr_i;
                tgt_be_o      <= be_i;
                tgt_wdata_o   <= wdata_i;
            end
        end
    end

    // answer stage: target data or zero for a null access
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ack_o   <= 1'b0;
            rdata_o <= `RDATA_ZERO;
        end else begin
            ack_o   <= pend_q;
            rdata_o <= pend_q ? (pend_null_q ? `RDATA_ZERO : tgt_rdata_i) : `RDATA_ZERO;
        end
    end

    // flag seen by software
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rom_remap_o <= 1'b0;
        end else begin
            rom_remap_o <= rom_remap_q;
        end
    end

    // decode, remap flag, ack and default base checks
    property p_rom_at_zero;
        @(posedge mclk_i) disable iff (sys_rst_i)
        req_i && !rom_remap_q && addr_i[31:26] == 6'h00 |=> target_o == TGT_BOOT_ROM;
    endproperty
    a_rom_at_zero: assert property (p_rom_at_zero) else $error("zero not decoded to rom");
    property p_periph;
        @(posedge mclk_i) disable iff (sys_rst_i)
        req_i && addr_i[31:24] == 8'hff |=> target_o == TGT_PERIPH && bridge_o
            && periph_slot_o == $past(addr_i[19:14]);
    endproperty
    a_periph: assert property (p_periph) else $error("peripheral decode wrong");
    property p_dspb_pram;
        @(posedge mclk_i) disable iff (sys_rst_i) req_i && addr_i[31:24] == 8'hfe |=> target_o == TGT_DSPB_PRAM;
    endproperty
    a_dspb_pram: assert property (p_dspb_pram) else $error("second dsp ram decode wrong");
    property p_dspa_pram;
        @(posedge mclk_i) disable iff (sys_rst_i)
        req_i && addr_i[31:24] == 8'hfd |=> target_o == TGT_DSPA_PRAM;
    endproperty
    a_dspa_pram: assert property (p_dspa_pram) else $error("first dsp ram decode wrong");
    property p_dspa_mbox;
        @(posedge mclk_i) disable iff (sys_rst_i)
        req_i && addr_i[31:24] == 8'hfa |=> target_o == TGT_DSPA_MBOX;
    endproperty
    a_dspa_mbox: assert property (p_dspa_mbox) else $error("first dsp mailbox decode wrong");
    property p_rsvd;
        @(posedge mclk_i) disable iff (sys_rst_i) req_i && addr_i[31:24] == 8'hfc |=> !tgt_req_o ##1 ack_o && rdata_o == 32'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved region not null");
    property p_mbox;
        @(posedge mclk_i) disable iff (sys_rst_i)
        req_i && addr_i[31:25] == 7'h7d |=> target_o == TGT_DSPB_MBOX || target_o == TGT_DSPA_MBOX;
    endproperty
    a_mbox: assert property (p_mbox) else $error("mailbox decode wrong");
    property p_rom;
        @(posedge mclk_i) disable iff (sys_rst_i) req_i && addr_i[31:24] == 8'hf9 |=> target_o == TGT_BOOT_ROM;
    endproperty
    a_rom: assert property (p_rom) else $error("boot rom region wrong");
    property p_remap_sticky;
        @(posedge mclk_i) disable iff (sys_rst_i) remap_set_i && !rst_seen_q |=> rom_remap_q [*2];
    endproperty
    a_remap_sticky: assert property (p_remap_sticky) else $error("remap flag not set");
    property p_ack;
        @(posedge mclk_i) disable iff (sys_rst_i) req_i |-> ##2 ack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("access not answered in two cycles");
    property p_one;
        @(posedge mclk_i) disable iff (sys_rst_i) tgt_req_o |-> target_o != TGT_NONE;
    endproperty
    a_one: assert property (p_one) else $error("request with no target");
    property p_def_dmc;
        @(posedge mclk_i) disable iff (sys_rst_i)
        $past(sys_rst_i) |-> bases_q.dmc0 == 6'h01 && bases_q.smc2 == 6'h08;
    endproperty
    a_def_dmc: assert property (p_def_dmc) else $error("default bases wrong");

    // external region and reserved write checks
    property p_int_floor;
        @(posedge mclk_i) disable iff (sys_rst_i)
        req_i && addr_i[31:24] >= 8'hf9 |=> target_o != TGT_SMC && target_o != TGT_DMC;
    endproperty
    a_int_floor: assert property (p_int_floor) else $error("internal region sent outside");

    property p_ext_granule;
        @(posedge mclk_i) disable iff (sys_rst_i)
        req_i && rom_remap_q && ext_en_q[0] && addr_i[31:26] == bases_q.smc0 && addr_i[31:24] < 8'hf9
            |=> target_o == TGT_SMC && ext_select_o == 2'h0;
    endproperty
    a_ext_granule: assert property (p_ext_granule) else $error("static region zero missed");

    property p_ext_any;
        @(posedge mclk_i) disable iff (sys_rst_i)
        req_i && rom_remap_q && ext_en_q[5] && addr_i[31:26] == bases_q.dmc1 && addr_i[31:24] < 8'hf9
            |=> target_o == TGT_SMC || target_o == TGT_DMC;
    endproperty
    a_ext_any: assert property (p_ext_any) else $error("dram region one not external");

    property p_null_write;
        @(posedge mclk_i) disable iff (sys_rst_i)
        req_i && wr_i && addr_i[31:24] == 8'hfc |=> !tgt_wr_o ##1 ack_o && rdata_o == 32'h0;
    endproperty
    a_null_write: assert property (p_null_write) else $error("reserved write not dropped");

    // configuration and flag checks
    property p_def_static;
        @(posedge mclk_i) disable iff (sys_rst_i)
        $past(sys_rst_i) |-> bases_q.smc0 == 6'h00 && bases_q.smc3 == 6'h0c && ext_en_q == 6'h3f;
    endproperty
    a_def_static: assert property (p_def_static) else $error("default static bases wrong");

    property p_base_load;
        @(posedge mclk_i) disable iff (sys_rst_i)
        base_wr_i && base_idx_i == 3'h4 |=> bases_q.dmc0 == $past(base_val_i) && ext_en_q[4] == $past(base_en_i);
    endproperty
    a_base_load: assert property (p_base_load) else $error("dram region zero not loaded");

    property p_boot_load;
        @(posedge mclk_i) disable iff (sys_rst_i)
        rst_seen_q |=> rom_remap_q == ($past(boot_s2_q) || $past(remap_set_i));
    endproperty
    a_boot_load: assert property (p_boot_load) else $error("remap flag not loaded from pin");

    property p_remap_off;
        @(posedge mclk_i) disable iff (sys_rst_i)
        req_i && rom_remap_q && addr_i[31:26] == 6'h00 |=> target_o != TGT_BOOT_ROM;
    endproperty
    a_remap_off: assert property (p_remap_off) else $error("rom still at zero after remap");

    // pass-through checks
    property p_pass;
        @(posedge mclk_i) disable iff (sys_rst_i)
        req_i && !route.null_access |=> tgt_req_o && tgt_addr_o == $past(addr_i) && tgt_wr_o == $past(wr_i);
    endproperty
    a_pass: assert property (p_pass) else $error("access not passed to target");

    property p_lanes;
        @(posedge mclk_i) disable iff (sys_rst_i)
        req_i |=> tgt_be_o == $past(be_i) && tgt_wdata_o == $past(wdata_i);
    endproperty
    a_lanes: assert property (p_lanes) else $error("byte lanes reordered");

    property p_bridge_only;
        @(posedge mclk_i) disable iff (sys_rst_i)
        bridge_o |-> target_o == TGT_PERIPH;
    endproperty
    a_bridge_only: assert property (p_bridge_only) else $error("bridge used for non peripheral");

    c_rom_boot: cover property (@(posedge mclk_i) req_i && route.target == TGT_BOOT_ROM);
    c_dmc: cover property (@(posedge mclk_i) req_i && route.target == TGT_DMC);
    c_null: cover property (@(posedge mclk_i) req_i && route.null_access);
    c_remap: cover property (@(posedge mclk_i) $rose(rom_remap_q));
    c_back_to_back: cover property (@(posedge mclk_i) req_i ##1 req_i);

endmodule : system_address_decoder

// ---- testbench/target_model.sv ----
/*
 * behavioural model of the targets behind the decoder: read data for the
 * cycle after a select. assumes the decoder's registered target outputs.
 */
`timescale 1ns/1ps

module target_model (
    input  wire logic        mclk_i,      // system clock
    input  wire logic        tgt_req_i,   // select pulse from decoder
    input  wire logic [31:0] tgt_addr_i,  // address from decoder
    output logic      [31:0] rdata_o      // read data to decoder
);
    logic [31:0] junk_q = 32'h5555aaaa;

    // idle lines toggle so a stale or unselected read cannot pass for data
    always_ff @(posedge mclk_i) begin
        junk_q <= ~junk_q;
    end

    // word keyed to the address, byte 0 in the low lane
    assign rdata_o = tgt_req_i ? (tgt_addr_i ^ 32'ha5a50f0f) : junk_q;
endmodule : target_model

// ---- testbench/test_system_address_decoder.sv ----
/*
 * self-checking bench of the system address decoder.
 * assumes target_model answers in the cycle after each select.
 */
`timescale 1ns/1ps

module test_system_address_decoder
    import addr_decoder_pkg::*;
;
    logic        mclk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        boot_pin = 1'b0;
    logic        remap_set = 1'b0;
    logic        base_wr = 1'b0;
    logic [2:0]  base_idx = 3'h0;
    logic [5:0]  base_val = 6'h00;
    logic        base_en = 1'b0;
    logic        req = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] addr = 32'h00000000;
    logic [3:0]  be = 4'h0;
    logic [31:0] wdata = 32'h00000000;
    logic [31:0] tgt_rdata;
    target_t     target;
    logic [1:0]  ext_sel;
    logic [5:0]  slot;
    logic        bridge, tgt_req, tgt_wr, ack, remap;
    logic [31:0] tgt_addr, tgt_wdata, rdata;
    logic [3:0]  tgt_be;
    int          errors = 0;
    int          total_checks = 0;

    always #25 mclk_i = ~mclk_i;

    system_address_decoder i_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .boot_select_pin_i(boot_pin),
        .remap_set_i(remap_set), .base_wr_i(base_wr), .base_idx_i(base_idx), .base_val_i(base_val),
        .base_en_i(base_en), .req_i(req), .wr_i(wr), .addr_i(addr), .be_i(be), .wdata_i(wdata),
        .tgt_rdata_i(tgt_rdata), .target_o(target), .ext_select_o(ext_sel), .periph_slot_o(slot),
        .bridge_o(bridge), .tgt_req_o(tgt_req), .tgt_wr_o(tgt_wr), .tgt_addr_o(tgt_addr),
        .tgt_be_o(tgt_be), .tgt_wdata_o(tgt_wdata), .ack_o(ack), .rdata_o(rdata), .rom_remap_o(remap));

    target_model i_tgt (.mclk_i(mclk_i), .tgt_req_i(tgt_req), .tgt_addr_i(tgt_addr), .rdata_o(tgt_rdata));

    task automatic chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            errors++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : chk

    task automatic finish_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    // reset 10 cycles with the boot pin at the given level
    task automatic do_reset(input logic pin);
        @(posedge mclk_i);
        boot_pin  <= pin;
        sys_rst_i <= 1'b1;
        repeat (10) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        #1;
        chk(remap === pin, "remap flag after reset");
    endtask : do_reset

    // one access; routing checked in the cycle after it is taken
    task automatic access(input logic w, input logic [31:0] a, input target_t t, input logic [1:0] cs,
                          input logic nul);
        int n;
        @(posedge mclk_i);
        req   <= 1'b1;
        wr    <= w;
        addr  <= a;
        be    <= a[3:0] | 4'h1;
        wdata <= ~a;
        @(posedge mclk_i);
        req <= 1'b0;
        #1;
        chk(target === t, "target");
        chk(tgt_req === !nul, "target select");
        chk(bridge === (t == TGT_PERIPH), "bridge");
        if (!nul) begin
            chk(tgt_addr === a && tgt_wr === w, "address or direction");
            chk(tgt_be === (a[3:0] | 4'h1), "byte lanes");
            if (w) chk(tgt_wdata === ~a, "write data");
        end
        if (t == TGT_PERIPH) chk(slot === a[19:14], "peripheral window");
        if (t == TGT_SMC || t == TGT_DMC) chk(ext_sel === cs, "chip select");
        for (n = 0; n < 3 && ack !== 1'b1; n++) begin
            @(posedge mclk_i);
            #1;
        end
        chk(ack === 1'b1, "no ack");
        chk(rdata === (nul ? 32'h00000000 : (a ^ 32'ha5a50f0f)), "read data");
    endtask : access

    task automatic set_base(input logic [2:0] idx, input logic [5:0] val, input logic en);
        @(posedge mclk_i);
        base_wr  <= 1'b1;
        base_idx <= idx;
        base_val <= val;
        base_en  <= en;
        @(posedge mclk_i);
        base_wr <= 1'b0;
    endtask : set_base

    task automatic test_internal_map;
        access(1'b0, 32'h00000004, TGT_BOOT_ROM, 2'h0, 1'b0);
        access(1'b0, 32'hff0bc010, TGT_PERIPH, 2'h0, 1'b0);
        access(1'b1, 32'hff028004, TGT_PERIPH, 2'h0, 1'b0);
        access(1'b0, 32'hfe000100, TGT_DSPB_PRAM, 2'h0, 1'b0);
        access(1'b0, 32'hfd00bffc, TGT_DSPA_PRAM, 2'h0, 1'b0);
        access(1'b0, 32'hfc000008, TGT_NONE, 2'h0, 1'b1);
        access(1'b1, 32'hfc000008, TGT_NONE, 2'h0, 1'b1);
        access(1'b0, 32'hfb000ffc, TGT_DSPB_MBOX, 2'h0, 1'b0);
        access(1'b0, 32'hfa000002, TGT_DSPA_MBOX, 2'h0, 1'b0);
        access(1'b0, 32'hf90007fe, TGT_BOOT_ROM, 2'h0, 1'b0);
    endtask : test_internal_map

    task automatic test_ext_defaults;
        access(1'b0, 32'h20000010, TGT_SMC, 2'h2, 1'b0);
        access(1'b1, 32'h33fffffc, TGT_SMC, 2'h3, 1'b0);
        access(1'b0, 32'h10000000, TGT_NONE, 2'h0, 1'b1);
    endtask : test_ext_defaults

    task automatic test_remap_and_move;
        @(posedge mclk_i);
        remap_set <= 1'b1;
        @(posedge mclk_i);
        remap_set <= 1'b0;
        repeat (2) @(posedge mclk_i);
        #1;
        chk(remap === 1'b1, "remap flag set");
        access(1'b0, 32'h00000004, TGT_SMC, 2'h0, 1'b0);
        set_base(3'h4, 6'h05, 1'b1);
        set_base(3'h5, 6'h06, 1'b1);
        access(1'b0, 32'h14000020, TGT_DMC, 2'h0, 1'b0);
        access(1'b1, 32'h18000008, TGT_DMC, 2'h1, 1'b0);
        set_base(3'h1, 6'h07, 1'b1);
        access(1'b0, 32'h1c000000, TGT_SMC, 2'h1, 1'b0);
        set_base(3'h0, 6'h00, 1'b0);
        access(1'b0, 32'h00000004, TGT_NONE, 2'h0, 1'b1);
        set_base(3'h4, 6'h00, 1'b1);
        access(1'b0, 32'h00000004, TGT_DMC, 2'h0, 1'b0);
        access(1'b0, 32'hfa000000, TGT_DSPA_MBOX, 2'h0, 1'b0);
    endtask : test_remap_and_move

    // two requests on consecutive edges give two acks in a row
    task automatic test_back_to_back;
        @(posedge mclk_i);
        req  <= 1'b1;
        wr   <= 1'b0;
        addr <= 32'hfe000040;
        @(posedge mclk_i);
        addr <= 32'hfb000080;
        @(posedge mclk_i);
        req <= 1'b0;
        #1;
        chk(target === TGT_DSPB_MBOX && tgt_req === 1'b1, "second select");
        chk(ack === 1'b1 && rdata === (32'hfe000040 ^ 32'ha5a50f0f), "first answer");
        @(posedge mclk_i);
        #1;
        chk(ack === 1'b1 && rdata === (32'hfb000080 ^ 32'ha5a50f0f), "second answer");
    endtask : test_back_to_back

    initial begin
        do_reset(1'b0);
        test_internal_map();
        test_ext_defaults();
        test_back_to_back();
        test_remap_and_move();
        do_reset(1'b1);
        access(1'b0, 32'h00000010, TGT_SMC, 2'h0, 1'b0);
        finish_test();
    end

    // watchdog, far beyond the roughly 100 cycles of the run
    initial begin
        #(50 * 5000);
        errors++;
        finish_test();
    end
endmodule : test_system_address_decoder
